// ==== hdl/exr_read_path.sv ====
// Read path of the two-wire serial slave of a 16-bit port expander.
//
// Contract
// RQ1: The master opens a read by addressing the device with the direction bit cleared.
// RQ2: The byte after a write address is latched as the register pointer.
// RQ3: The master then sends a repeated start and the address again with the direction bit set.
// RQ4: On a read the device shifts out the register chosen by the pointer, most significant bit first.
// RQ5: After each returned byte the pointer toggles to the partner register of the same pair.
// RQ6: The byte to be returned is captured at the falling clock edge that ends the acknowledge pulse.
// RQ7: Bytes keep coming for as long as the master acknowledges, without limit.
// RQ8: The master ends the read by not acknowledging its last byte.
// RQ9: A stop condition at any bit returns the device to idle.
// RQ10: Eight registers form four pairs: input, output, polarity inversion and configuration, output at 2 and 3.
// RQ11: Reading an input register clears its interrupt at the rising clock edge of the acknowledge bit.
// RQ12: Interrupt clearing is per port, so reading one port never clears the other.
// RQ13: After a not-acknowledge the device releases the data line and waits for a start or stop.
`timescale 1ns/1ns

module exr_read_path
(
	// Clock and reset.
	input  wire logic                   MCLK,
	input  wire logic                   RESET_N,
	// Serial bus, data line as open drain.
	input  wire logic                   SCL,
	input  wire logic                   SDA_IN,
	output logic                        SDA_OUT,
	output logic                        SDA_OE_N,
	// Address straps.
	input  wire logic [2:0]             ADDR_SEL,
	// Register contents, port 1 in bits 15:8.
	input  wire logic [15:0]            INPUT_REG,
	input  wire logic [15:0]            OUTPUT_REG,
	input  wire logic [15:0]            POLARITY_REG,
	input  wire logic [15:0]            CONFIG_REG,
	// Pointer and interrupt clear.
	output logic [exr_pkg::EXR_PTR_MSB:0] POINTER,
	output logic [1:0]                  INT_CLR
);
	import exr_pkg::*;

	exr_regs_t r_reg;
	exr_regs_t r_next;
	logic      scl_rise;
	logic      scl_fall;
	logic      start_cond;
	logic      stop_cond;
	logic [15:0] pair_word;
	logic [7:0]  sel_byte;

	assign scl_rise   = SCL && !r_reg.scl_prev;
	assign scl_fall   = !SCL && r_reg.scl_prev;
	assign start_cond = SCL && r_reg.scl_prev && r_reg.sda_prev && !SDA_IN;
	assign stop_cond  = SCL && r_reg.scl_prev && !r_reg.sda_prev && SDA_IN;

	always_comb
	begin
		case (r_reg.ptr[EXR_PTR_MSB:1]) // RQ10
			EXR_PAIR_INPUT: pair_word = INPUT_REG;
			EXR_PAIR_OUT:   pair_word = OUTPUT_REG;
			EXR_PAIR_POL:   pair_word = POLARITY_REG;
			EXR_PAIR_CFG:   pair_word = CONFIG_REG;
			default:        pair_word = 16'h0000;
		endcase
		sel_byte = r_reg.ptr[EXR_PTR_LSB] ? pair_word[15:8] : pair_word[7:0];
	end

	always_comb
	begin
		r_next          = r_reg;
		r_next.scl_prev = SCL;
		r_next.sda_prev = SDA_IN;
		r_next.int_clr  = 2'h0;
		r_next.sda_out  = 1'b0;
		if (stop_cond)
		begin
			r_next.state    = EXR_IDLE; // RQ9
			r_next.sda_oe_n = 1'b1;
		end
		else if (start_cond)
		begin
			r_next.state    = EXR_ADDR;
			r_next.bit_cnt  = 4'h0;
			r_next.sda_oe_n = 1'b1;
		end
		else
		begin
			case (r_reg.state)
				EXR_ADDR, EXR_PTR:
				begin
					if (scl_rise)
					begin
						r_next.shreg   = {r_reg.shreg[6:0], SDA_IN};
						r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
					end
					else if (scl_fall && r_reg.bit_cnt == EXR_BYTE_BITS)
					begin
						if (r_reg.state == EXR_PTR)
						begin
							r_next.ptr      = r_reg.shreg[EXR_PTR_MSB:0]; // RQ2
							r_next.state    = EXR_ACK_PTR;
							r_next.sda_oe_n = 1'b0;
						end
						else if (r_reg.shreg[7:1] == {EXR_ADDR_HI, ADDR_SEL})
						begin
							r_next.rw       = r_reg.shreg[EXR_RW_BIT];
							r_next.state    = EXR_ACK_ADDR;
							r_next.sda_oe_n = 1'b0;
						end
						else
						begin
							r_next.state = EXR_WAIT;
						end
					end
				end
				EXR_ACK_ADDR:
				begin
					if (scl_fall)
					begin
						r_next.bit_cnt = 4'h0;
						if (r_reg.rw)
						begin
							r_next.shreg    = sel_byte; // RQ6
							r_next.sda_oe_n = sel_byte[7]; // RQ4
							r_next.state    = EXR_TX;
						end
						else
						begin
							r_next.sda_oe_n = 1'b1;
							r_next.state    = EXR_PTR;
						end
					end
				end
				EXR_ACK_PTR:
				begin
					if (scl_fall)
					begin
						r_next.sda_oe_n = 1'b1;
						r_next.state    = EXR_WAIT;
					end
				end
				EXR_TX:
				begin
					if (scl_fall)
					begin
						if (r_reg.bit_cnt == EXR_LAST_BIT)
						begin
							r_next.sda_oe_n       = 1'b1;
							r_next.ptr[EXR_PTR_LSB] = !r_reg.ptr[EXR_PTR_LSB]; // RQ5
							r_next.state          = EXR_ACK_RX;
						end
						else
						begin
							r_next.shreg    = {r_reg.shreg[6:0], 1'b0};
							r_next.sda_oe_n = r_reg.shreg[6]; // RQ4
							r_next.bit_cnt  = r_reg.bit_cnt + 4'h1;
						end
					end
				end
				EXR_ACK_RX:
				begin
					if (scl_rise)
					begin
						r_next.acked = !SDA_IN;
						if (r_reg.ptr[EXR_PTR_MSB:1] == EXR_PAIR_INPUT)
						begin
							r_next.int_clr = r_reg.ptr[EXR_PTR_LSB] ? 2'h1 : 2'h2; // RQ11 RQ12
						end
					end
					else if (scl_fall)
					begin
						r_next.bit_cnt = 4'h0;
						if (r_reg.acked)
						begin
							r_next.shreg    = sel_byte; // RQ6 RQ7
							r_next.sda_oe_n = sel_byte[7];
							r_next.state    = EXR_TX;
						end
						else
						begin
							r_next.state = EXR_WAIT; // RQ13
						end
					end
				end
				EXR_IDLE, EXR_WAIT:
				begin
					r_next.sda_oe_n = 1'b1; // RQ13
				end
				default:
				begin
					r_next.state    = EXR_IDLE;
					r_next.sda_oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			r_reg <= '{state: EXR_IDLE, scl_prev: 1'b1, sda_prev: 1'b1, bit_cnt: 4'h0, shreg: 8'h00,
			           ptr: EXR_PTR_RESET, rw: 1'b0, acked: 1'b0, sda_out: 1'b0, sda_oe_n: 1'b1,
			           int_clr: 2'h0};
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign SDA_OUT  = r_reg.sda_out;
	assign SDA_OE_N = r_reg.sda_oe_n;
	assign POINTER  = r_reg.ptr;
	assign INT_CLR  = r_reg.int_clr;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	chk_ptr_latch: assert property ((r_reg.state == EXR_PTR && r_reg.bit_cnt == EXR_BYTE_BITS && scl_fall && // RQ2
		!start_cond && !stop_cond) |=> (POINTER == $past(r_reg.shreg[2:0]) && r_reg.state == EXR_ACK_PTR))
		else $error("Pointer byte not latched.");
	chk_msb_first: assert property ((r_reg.state == EXR_ACK_ADDR && r_reg.rw && scl_fall && !stop_cond && // RQ4
		!start_cond) |=> (SDA_OE_N == $past(sel_byte[7]) && r_reg.state == EXR_TX))
		else $error("First data bit is not the most significant bit.");
	chk_ptr_toggle: assert property ((r_reg.state == EXR_TX && r_reg.bit_cnt == EXR_LAST_BIT && scl_fall && // RQ5
		!stop_cond && !start_cond) |=> (POINTER == {$past(POINTER[2:1]), !$past(POINTER[0])} && SDA_OE_N))
		else $error("Pointer did not move to partner register.");
	chk_capture_edge: assert property ((r_reg.state != EXR_TX ##1 r_reg.state == EXR_TX) |-> // RQ6
		($past(r_reg.scl_prev) && !$past(SCL)))
		else $error("Byte captured away from a falling clock edge.");
	chk_stream_on: assert property ((r_reg.state == EXR_ACK_RX && r_reg.acked && scl_fall && !stop_cond && // RQ7
		!start_cond) |=> (r_reg.state == EXR_TX && r_reg.bit_cnt == 4'h0))
		else $error("Acknowledged read did not continue.");
	chk_stop_idle: assert property (stop_cond |=> (r_reg.state == EXR_IDLE && SDA_OE_N)) // RQ9
		else $error("Stop did not return to idle.");
	chk_pair_map: assert property ((POINTER == 3'h2) |-> (sel_byte == OUTPUT_REG[7:0])) // RQ10
		else $error("Output pair not at pointer 2.");
	chk_int_clear: assert property ((r_reg.state == EXR_ACK_RX && scl_rise && !stop_cond && !start_cond && // RQ11
		POINTER[2:1] == EXR_PAIR_INPUT) |=> (INT_CLR == ($past(POINTER[0]) ? 2'h1 : 2'h2)))
		else $error("Input read did not clear its interrupt.");
	chk_int_port: assert property (INT_CLR != 2'h3) // RQ12
		else $error("Both port interrupts cleared at once.");
	chk_nack_release: assert property ((r_reg.state == EXR_ACK_RX && !r_reg.acked && scl_fall && !stop_cond && // RQ13
		!start_cond) |=> (r_reg.state == EXR_WAIT && SDA_OE_N) [*2])
		else $error("Data line not released after not-acknowledge.");

	cov_read_byte: cover property (r_reg.state == EXR_ACK_ADDR && r_reg.rw ##1 r_reg.state == EXR_TX);
	cov_read_stream: cover property (r_reg.state == EXR_ACK_RX && r_reg.acked && scl_fall ##1 r_reg.state == EXR_TX);
	cov_stop_mid: cover property (r_reg.state == EXR_TX && stop_cond);
	cov_restart: cover property (r_reg.state == EXR_WAIT && start_cond);

endmodule

// ==== include/exr_pkg.sv ====
// Constants and types for the expander register read path.
package exr_pkg;

	// Fixed upper four bits of the seven-bit device address.
	localparam logic [3:0] EXR_ADDR_HI    = 4'h4;
	localparam logic [3:0] EXR_BYTE_BITS  = 4'h8;
	localparam logic [3:0] EXR_LAST_BIT   = 4'h7;
	localparam logic [2:0] EXR_PTR_RESET  = 3'h0;
	localparam int         EXR_PTR_LSB    = 0;
	localparam int         EXR_PTR_MSB    = 2;
	localparam int         EXR_RW_BIT     = 0;

	// Register pairs, selected by pointer bits 2:1.
	localparam logic [1:0] EXR_PAIR_INPUT = 2'h0;
	localparam logic [1:0] EXR_PAIR_OUT   = 2'h1;
	localparam logic [1:0] EXR_PAIR_POL   = 2'h2;
	localparam logic [1:0] EXR_PAIR_CFG   = 2'h3;

	typedef enum logic [7:0]
	{
		EXR_IDLE     = 8'h01,
		EXR_ADDR     = 8'h02,
		EXR_ACK_ADDR = 8'h04,
		EXR_PTR      = 8'h08,
		EXR_ACK_PTR  = 8'h10,
		EXR_TX       = 8'h20,
		EXR_ACK_RX   = 8'h40,
		EXR_WAIT     = 8'h80
	} exr_state_t;

	typedef struct packed
	{
		exr_state_t  state;
		logic        scl_prev;
		logic        sda_prev;
		logic [3:0]  bit_cnt;
		logic [7:0]  shreg;
		logic [2:0]  ptr;
		logic        rw;
		logic        acked;
		logic        sda_out;
		logic        sda_oe_n;
		logic [1:0]  int_clr;
	} exr_regs_t;

endpackage

// ==== testbench/exr_bus_master.sv ====
// Two-wire bus master model driving the serial clock and data line.
`timescale 1ns/1ns

module exr_bus_master
(
	// Clock.
	input  wire logic MCLK,
	// Bus lines.
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_drv
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask

	task automatic start();
		sda_drv = 1'b1;
		wt(3);
		scl = 1'b1;
		wt(4);
		sda_drv = 1'b0;
		wt(4);
		scl = 1'b0;
		wt(3);
	endtask

	task automatic stop();
		sda_drv = 1'b0;
		wt(3);
		scl = 1'b1;
		wt(4);
		sda_drv = 1'b1;
		wt(4);
	endtask

	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		wt(3);
		scl = 1'b1;
		wt(2);
		r = sda_wire;
		wt(2);
		scl = 1'b0;
		wt(3);
	endtask

	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
		logic t;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], t);
			q[i] = t;
		end
		bit_io(a, ack);
	endtask
endmodule

// ==== testbench/exr_read_path_tb.sv ====
// Self-checking testbench for the read path against a bus master model.
`timescale 1ns/1ns

module exr_read_path_tb;
	import exr_pkg::*;

	logic        mclk;
	logic        reset_n;
	logic [2:0]  addr_sel;
	logic [15:0] regs [4];
	logic        scl;
	logic        sda_drv;
	logic        sda_out;
	logic        sda_oe_n;
	logic [2:0]  pointer;
	logic [1:0]  int_clr;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          clr_cnt [2] = '{0, 0};
	wire         sda_wire = sda_drv & (sda_oe_n | sda_out);

	exr_read_path uut (.MCLK(mclk), .RESET_N(reset_n), .SCL(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out),
		.SDA_OE_N(sda_oe_n), .ADDR_SEL(addr_sel), .INPUT_REG(regs[0]), .OUTPUT_REG(regs[1]),
		.POLARITY_REG(regs[2]), .CONFIG_REG(regs[3]), .POINTER(pointer), .INT_CLR(int_clr));
	exr_bus_master m (.MCLK(mclk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		clr_cnt[0] += int_clr[0];
		clr_cnt[1] += int_clr[1];
	end

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic rd(input logic [2:0] p, input int n);
		logic [7:0] q;
		logic       a;
		logic [2:0] e;
		e = p;
		m.start();
		m.xfer({EXR_ADDR_HI, addr_sel, 1'b0}, 1'b1, q, a);
		cmp({7'h0, a}, 8'h00);
		m.xfer({5'h0, p}, 1'b1, q, a);
		cmp({7'h0, a}, 8'h00);
		cmp({5'h0, pointer}, {5'h0, p});
		m.start();
		m.xfer({EXR_ADDR_HI, addr_sel, 1'b1}, 1'b1, q, a);
		cmp({7'h0, a}, 8'h00);
		for (int i = 0; i < n; i++)
		begin
			m.xfer(8'hFF, i == n - 1, q, a);
			cmp(q, e[0] ? regs[e[2:1]][15:8] : regs[e[2:1]][7:0]);
			e[0] = ~e[0];
		end
		cmp({5'h0, pointer}, {5'h0, e});
		cmp({7'h0, sda_oe_n}, 8'h01);
		m.stop();
	endtask

	task automatic t_pairs();
		for (int p = 0; p < 8; p++)
			rd(p[2:0], 2);
		cmp(clr_cnt[0][7:0], 8'h02);
		cmp(clr_cnt[1][7:0], 8'h02);
	endtask

	task automatic t_clear();
		int c0;
		int c1;
		c0 = clr_cnt[0];
		c1 = clr_cnt[1];
		rd(3'h1, 1);
		cmp(clr_cnt[0][7:0], c0[7:0]);
		cmp(clr_cnt[1][7:0], c1[7:0] + 8'h01);
	endtask

	task automatic t_long();
		addr_sel = 3'h2;
		rd(3'h7, 5);
	endtask

	task automatic t_stop_mid();
		logic [7:0] q;
		logic       a;
		m.start();
		m.xfer({EXR_ADDR_HI, addr_sel, 1'b0}, 1'b1, q, a);
		m.xfer(8'h01, 1'b1, q, a);
		m.start();
		m.xfer({EXR_ADDR_HI, addr_sel, 1'b1}, 1'b1, q, a);
		cmp({7'h0, a}, 8'h00);
		m.stop();
		cmp({5'h0, pointer}, 8'h01);
		cmp({7'h0, sda_oe_n}, 8'h01);
	endtask

	task automatic t_abort();
		logic [7:0] q;
		logic       a;
		logic [2:0] k;
		k = pointer;
		m.start();
		m.xfer({EXR_ADDR_HI, addr_sel, 1'b0}, 1'b1, q, a);
		for (int i = 0; i < 3; i++)
			m.bit_io(1'b1, a);
		m.stop();
		cmp({5'h0, pointer}, {5'h0, k});
		m.start();
		m.xfer({EXR_ADDR_HI, addr_sel ^ 3'h1, 1'b0}, 1'b1, q, a);
		cmp({7'h0, a}, 8'h01);
		m.stop();
		rd(3'h6, 1);
	endtask

	initial
	begin
		reset_n = 1'b0;
		addr_sel = 3'h5;
		regs = '{16'hA55A, 16'h3CC3, 16'h0FF0, 16'h96E1};
		repeat (4) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		m.wt(2);
		t_pairs();
		t_clear();
		t_long();
		t_stop_mid();
		t_abort();
		end_of_test();
	end

	initial
	begin
		repeat (40000) @(posedge mclk);
		n_mismatch++;
		end_of_test();
	end
endmodule
